// ==== common/rsa_pkg.sv ====
// rsa_pkg: constants and types for the recorder status annunciator
// assumes a 100 MHz system clock and synchronous active-low reset
package rsa_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned CLK_NS = 10;
  // time reference loss, in seconds
  localparam int unsigned GPS_LOSS_S = 300;
  // long hold of the test button, in seconds
  localparam int unsigned HOLD_S = 5;
  // triggered relay least on-time, in ms
  localparam int unsigned TRIG_MIN_MS = 500;
  // debounce interval, in ms
  localparam int unsigned DEB_MS = 20;
  // tick period of the slow enable, in microseconds
  localparam int unsigned TICK_US = 1000;
  localparam int unsigned TICK_CYC = (TICK_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GPS_LOSS_TICKS = GPS_LOSS_S * 1000 + 1;
  localparam int unsigned HOLD_TICKS = HOLD_S * 1000;
  localparam int unsigned TRIG_MIN_TICKS = TRIG_MIN_MS;
  localparam int unsigned DEB_TICKS = DEB_MS;
  // temperature limit in whole degrees
  localparam logic [7:0] TEMP_LIMIT = 8'h3C;
  // sensor disagreement limit in degrees
  localparam logic [7:0] TEMP_DIFF_LIMIT = 8'h0A;
  // tone sweep: divider start and end values and step size
  localparam logic [15:0] TONE_DIV_LOW = 16'h61A8;
  localparam logic [15:0] TONE_DIV_HIGH = 16'h1388;
  localparam logic [15:0] TONE_DIV_STEP = 16'h00C8;
  // number of host channels
  localparam int unsigned N_CHAN = 2;
  // number of input-board sensors
  localparam int unsigned N_SENS = 4;

  typedef enum logic [2:0] {
    RSA_ST_SELFTEST = 3'b000,
    RSA_ST_ARMED    = 3'b001,
    RSA_ST_TESTING  = 3'b011,
    RSA_ST_DISARMED = 3'b010,
    RSA_ST_REARM    = 3'b110
  } rsa_state_type;
endpackage

// ==== hw/rsa_tone.sv ====
// rsa_tone: rising-pitch tone generator for the disarm confirmation
// assumes a one-cycle start pulse and synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module rsa_tone (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  output logic tone_out,
  output logic busy
);
  import rsa_pkg::*;
  logic [15:0] div_reg, div_next;
  logic [15:0] cnt_reg, cnt_next;
  logic tone_reg, tone_next;
  logic busy_reg, busy_next;

  always_comb begin
    div_next = div_reg;
    cnt_next = cnt_reg;
    tone_next = tone_reg;
    busy_next = busy_reg;
    if (start) begin
      busy_next = 1'b1;
      div_next = TONE_DIV_LOW;
      cnt_next = 16'h0000;
    end else if (busy_reg) begin
      if (cnt_reg >= div_reg) begin
        // each half period shortens, so the pitch rises; see RULE17
        cnt_next = 16'h0000;
        tone_next = ~tone_reg;
        if (div_reg <= TONE_DIV_HIGH) begin
          busy_next = 1'b0;
          tone_next = 1'b0;
        end else begin
          div_next = div_reg - TONE_DIV_STEP;
        end
      end else begin
        cnt_next = cnt_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 16'h0000;
      cnt_reg <= 16'h0000;
      tone_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      cnt_reg <= cnt_next;
      tone_reg <= tone_next;
      busy_reg <= busy_next;
    end
  end

  assign tone_out = tone_reg;
  assign busy = busy_reg;

  property p_tone_quiet;
    @(posedge clk) disable iff (!rst_n) !busy_reg |=> !tone_reg || start;
  endproperty
  a_tone_quiet: assert property (p_tone_quiet) else $error("tone active while idle"); // see RULE17
endmodule
`default_nettype wire

// ==== hw/rsa_top.sv ====
// rsa_top: front-panel indicators, status relays and test button logic
// assumes all inputs synchronous to clk; host-facing flags are pulses
// Function
// RULE1: power lamp lit while supply present
// RULE2: on-line off until self-test passes, then acquiring
// RULE3: data lamp on record, off on directory read
// RULE4: data lamp flickers during flash writes
// RULE5: comms lamp lit during host session
// RULE6: only one host channel active at once
// RULE7: attention lamp on any self-test problem
// RULE8: attention held until event log read
// RULE9: time fault after five minutes reception loss
// RULE10: keep operating on internal oscillator
// RULE11: storage fault lamp on flash problem
// RULE12: comms fault lamp on remote channel problem
// RULE13: temperature fault: over limit, unreadable, disagreement
// RULE14: armed press runs tests then manual trigger
// RULE15: test fault lights attention and logs cause
// RULE16: five second hold disarms, on-line goes out
// RULE17: rising tone on entering disarmed state
// RULE18: disarmed short press rearms, no test record
// RULE19: log message on disarm and rearm
// RULE20: triggered relay held, at least 500 ms
// RULE21: power, on-line, attention relays mirror lamps
// RULE22: relays open unless function active
// RULE23: printer gets log, status, trigger records
// RULE24: debounced button, hold timed by counter
`timescale 1ns/1ps
`default_nettype none
module rsa_top #(
  parameter int unsigned GPS_LOSS = rsa_pkg::GPS_LOSS_TICKS,
  parameter int unsigned HOLD = rsa_pkg::HOLD_TICKS,
  parameter int unsigned TICK = rsa_pkg::TICK_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic selftest_done,
  input wire logic selftest_fail,
  input wire logic acquiring,
  input wire logic record_ready,
  input wire logic dir_read,
  input wire logic flash_writing,
  input wire logic flash_fault,
  input wire logic [rsa_pkg::N_CHAN-1:0] chan_req,
  input wire logic [rsa_pkg::N_CHAN-1:0] chan_end,
  input wire logic log_read,
  input wire logic gps_lock,
  input wire logic remote_fault,
  input wire logic [rsa_pkg::N_SENS-1:0] sens_ok,
  input wire logic [rsa_pkg::N_SENS*8-1:0] sens_temp,
  input wire logic triggered,
  input wire logic printer_present,
  input wire logic btn_raw,
  output logic led_power,
  output logic led_online,
  output logic led_data,
  output logic led_comms,
  output logic led_attention,
  output logic led_time_fault,
  output logic led_storage_fault,
  output logic led_comms_fault,
  output logic led_temp_fault,
  output logic led_spare,
  output logic relay_power,
  output logic relay_online,
  output logic relay_triggered,
  output logic relay_attention,
  output logic [rsa_pkg::N_CHAN-1:0] chan_grant,
  output logic run_tests,
  output logic manual_trigger,
  output logic armed,
  output logic log_disarm,
  output logic log_rearm,
  output logic log_test_fault,
  output logic print_log,
  output logic print_status,
  output logic print_record,
  output logic osc_holdover,
  output logic tone_out
);
  import rsa_pkg::*;
  function automatic logic [7:0] absdiff(input logic [7:0] a, input logic [7:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction
  // slow tick enable
  logic [31:0] div_reg, div_next;
  logic tick;
  always_comb begin
    tick = (div_reg == TICK - 1);
    div_next = tick ? 32'h0000_0000 : div_reg + 32'h0000_0001;
  end
  // button debounce and hold timer
  logic btn_reg, btn_next;
  logic [7:0] deb_reg, deb_next;
  logic [15:0] hold_reg, hold_next;
  logic long_done_reg, long_done_next;
  logic short_press, long_hold;
  always_comb begin
    btn_next = btn_reg;
    deb_next = deb_reg;
    hold_next = hold_reg;
    long_done_next = long_done_reg;
    short_press = 1'b0;
    long_hold = 1'b0;
    if (btn_raw == btn_reg) begin
      deb_next = 8'h00;
    end else if (tick) begin
      // a level must hold steady before it counts; see RULE24
      if (deb_reg == 8'(DEB_TICKS - 1)) begin
        btn_next = btn_raw;
        deb_next = 8'h00;
        short_press = !btn_raw && btn_reg && !long_done_reg;
      end else begin
        deb_next = deb_reg + 8'h01;
      end
    end
    if (!btn_reg) begin
      hold_next = 16'h0000;
      long_done_next = 1'b0;
    end else if (tick && !long_done_reg) begin
      if (hold_reg == 16'(HOLD - 1)) begin
        long_hold = 1'b1; // see RULE16
        long_done_next = 1'b1;
      end else begin
        hold_next = hold_reg + 16'h0001;
      end
    end
  end
  // arming state machine
  rsa_state_type st_reg, st_next;
  logic tone_start, tone_busy, tone_pin;
  logic run_tests_next, man_trig_next, log_dis_next, log_rearm_next, log_tf_next;
  logic run_tests_reg, man_trig_reg, log_dis_reg, log_rearm_reg, log_tf_reg;
  logic test_fault;
  always_comb begin
    st_next = st_reg;
    tone_start = 1'b0;
    run_tests_next = 1'b0;
    man_trig_next = 1'b0;
    log_dis_next = 1'b0;
    log_rearm_next = 1'b0;
    log_tf_next = 1'b0;
    test_fault = 1'b0;
    case (st_reg)
      RSA_ST_SELFTEST: begin
        st_next = (selftest_done && !selftest_fail) ? RSA_ST_ARMED : st_reg; // see RULE2
      end
      RSA_ST_ARMED: begin
        if (long_hold) begin
          st_next = RSA_ST_DISARMED; // see RULE16
          tone_start = 1'b1; // see RULE17
          log_dis_next = 1'b1; // see RULE19
        end else if (short_press) begin
          st_next = RSA_ST_TESTING; // see RULE14
          run_tests_next = 1'b1;
        end
      end
      RSA_ST_TESTING: begin
        if (selftest_done) begin
          st_next = RSA_ST_ARMED;
          man_trig_next = 1'b1; // see RULE14
          if (selftest_fail) begin
            test_fault = 1'b1; // see RULE15
            log_tf_next = 1'b1;
          end
        end
      end
      RSA_ST_DISARMED: begin
        st_next = short_press ? RSA_ST_REARM : st_reg; // see RULE18
      end
      RSA_ST_REARM: begin
        // rearm only: no manual trigger here; see RULE18
        st_next = RSA_ST_ARMED;
        log_rearm_next = 1'b1; // see RULE19
      end
      default: st_next = RSA_ST_SELFTEST;
    endcase
  end
  rsa_tone u_tone (
    .clk(clk),
    .rst_n(rst_n),
    .start(tone_start),
    .tone_out(tone_pin),
    .busy(tone_busy)
  );
  // indicator and relay state
  logic data_reg, data_next;
  logic attn_reg, attn_next;
  logic [31:0] gps_reg, gps_next;
  logic [N_CHAN-1:0] grant_reg, grant_next;
  logic [15:0] trig_cnt_reg, trig_cnt_next;
  logic [23:0] flick_reg, flick_next;
  logic temp_bad;
  logic online_next, trig_rel_next, data_led_next, tf_next, tone_next;
  logic online_reg, trig_rel_reg, data_led_reg, tf_reg, tone_reg;
  logic pwr_reg, comms_reg, sf_reg, cf_reg, temp_reg;
  logic prt_log_reg, prt_stat_reg, prt_rec_reg, trig_d_reg;
  always_comb begin
    temp_bad = 1'b0;
    for (int i = 0; i < N_SENS; i++) begin
      // neighbours compared round the ring, so no select runs out of range
      temp_bad = temp_bad || !sens_ok[i] || sens_temp[i*8 +: 8] > TEMP_LIMIT || // see RULE13
        absdiff(sens_temp[i*8 +: 8], sens_temp[((i + 1) % N_SENS)*8 +: 8]) > TEMP_DIFF_LIMIT;
    end
    // set wins over the directory-read clear; see RULE3
    data_next = record_ready ? 1'b1 : (dir_read ? 1'b0 : data_reg);
    // set wins over the log-read clear; see RULE7 RULE8 RULE15
    attn_next = (selftest_fail || test_fault) ? 1'b1 : (log_read ? 1'b0 : attn_reg);
    // loss timer only; timing carries on regardless; see RULE9 RULE10
    gps_next = gps_lock ? 32'h0000_0000 :
      ((tick && gps_reg != GPS_LOSS) ? gps_reg + 32'h0000_0001 : gps_reg);
    tf_next = (gps_reg == GPS_LOSS);
    // one channel at a time, lowest index first; see RULE6
    grant_next = grant_reg & ~chan_end;
    if (grant_next == '0) begin
      for (int i = N_CHAN - 1; i >= 0; i--) begin
        if (chan_req[i] && !chan_end[i]) begin
          grant_next = '0;
          grant_next[i] = 1'b1;
        end
      end
    end
    flick_next = flash_writing ? flick_reg + 24'h00_0001 : 24'h00_0000;
    data_led_next = data_reg ^ (flash_writing && flick_reg[22]); // see RULE4
    online_next = (st_reg != RSA_ST_SELFTEST) && (st_reg != RSA_ST_DISARMED) && acquiring; // see RULE2 RULE16
    // hold for the least on-time after the trigger ends; see RULE20
    trig_cnt_next = triggered ? 16'(TRIG_MIN_TICKS) :
      ((tick && trig_cnt_reg != 16'h0000) ? trig_cnt_reg - 16'h0001 : trig_cnt_reg);
    trig_rel_next = triggered || trig_cnt_reg != 16'h0000;
    tone_next = tone_pin && tone_busy;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      div_reg <= 32'h0000_0000;
      btn_reg <= 1'b0;
      deb_reg <= 8'h00;
      hold_reg <= 16'h0000;
      long_done_reg <= 1'b0;
      st_reg <= RSA_ST_SELFTEST;
      run_tests_reg <= 1'b0;
      man_trig_reg <= 1'b0;
      log_dis_reg <= 1'b0;
      log_rearm_reg <= 1'b0;
      log_tf_reg <= 1'b0;
      data_reg <= 1'b0;
      attn_reg <= 1'b0;
      gps_reg <= 32'h0000_0000;
      grant_reg <= '0;
      trig_cnt_reg <= 16'h0000;
      flick_reg <= 24'h00_0000;
      online_reg <= 1'b0;
      trig_rel_reg <= 1'b0;
      data_led_reg <= 1'b0;
      tf_reg <= 1'b0;
      tone_reg <= 1'b0;
      pwr_reg <= 1'b0;
      comms_reg <= 1'b0;
      sf_reg <= 1'b0;
      cf_reg <= 1'b0;
      temp_reg <= 1'b0;
      prt_log_reg <= 1'b0;
      prt_stat_reg <= 1'b0;
      prt_rec_reg <= 1'b0;
      trig_d_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      btn_reg <= btn_next;
      deb_reg <= deb_next;
      hold_reg <= hold_next;
      long_done_reg <= long_done_next;
      st_reg <= st_next;
      run_tests_reg <= run_tests_next;
      man_trig_reg <= man_trig_next;
      log_dis_reg <= log_dis_next;
      log_rearm_reg <= log_rearm_next;
      log_tf_reg <= log_tf_next;
      data_reg <= data_next;
      attn_reg <= attn_next;
      gps_reg <= gps_next;
      grant_reg <= grant_next;
      trig_cnt_reg <= trig_cnt_next;
      flick_reg <= flick_next;
      online_reg <= online_next;
      trig_rel_reg <= trig_rel_next;
      data_led_reg <= data_led_next;
      tf_reg <= tf_next;
      tone_reg <= tone_next;
      pwr_reg <= supply_ok; // see RULE1
      comms_reg <= |grant_reg; // see RULE5
      sf_reg <= flash_fault; // see RULE11
      cf_reg <= remote_fault; // see RULE12
      temp_reg <= temp_bad; // see RULE13
      // printer events, only with a printer attached; see RULE23
      prt_log_reg <= printer_present && (log_dis_next || log_rearm_next || log_tf_next || selftest_fail);
      prt_stat_reg <= printer_present && man_trig_next;
      prt_rec_reg <= printer_present && triggered && !trig_d_reg;
      trig_d_reg <= triggered;
    end
  end
  // power, on-line, attention relays mirror lamp registers; all open after reset; see RULE21 RULE22
  assign led_power = pwr_reg;
  assign relay_power = pwr_reg;
  assign led_online = online_reg;
  assign relay_online = online_reg;
  assign led_attention = attn_reg;
  assign relay_attention = attn_reg;
  assign relay_triggered = trig_rel_reg;
  assign led_data = data_led_reg;
  assign led_comms = comms_reg;
  assign led_time_fault = tf_reg;
  assign led_storage_fault = sf_reg;
  assign led_comms_fault = cf_reg;
  assign led_temp_fault = temp_reg;
  // unused indicator held dark
  assign led_spare = 1'b0;
  assign chan_grant = grant_reg;
  assign run_tests = run_tests_reg;
  assign manual_trigger = man_trig_reg;
  assign armed = online_reg;
  assign log_disarm = log_dis_reg;
  assign log_rearm = log_rearm_reg;
  assign log_test_fault = log_tf_reg;
  assign print_log = prt_log_reg;
  assign print_status = prt_stat_reg;
  assign print_record = prt_rec_reg;
  assign osc_holdover = tf_reg;
  assign tone_out = tone_reg;
  property p_one_chan;
    @(posedge clk) disable iff (!rst_n) $onehot0(grant_reg);
  endproperty
  a_one_chan: assert property (p_one_chan) else $error("two channels granted"); // see RULE6
  property p_attn_hold;
    @(posedge clk) disable iff (!rst_n) attn_reg && !log_read |=> attn_reg;
  endproperty
  a_attn_hold: assert property (p_attn_hold) else $error("attention dropped early"); // see RULE8
  property p_attn_set;
    @(posedge clk) disable iff (!rst_n) selftest_fail |=> attn_reg;
  endproperty
  a_attn_set: assert property (p_attn_set) else $error("attention not set"); // see RULE7
  property p_data_set;
    @(posedge clk) disable iff (!rst_n) record_ready |=> data_reg;
  endproperty
  a_data_set: assert property (p_data_set) else $error("record not flagged"); // see RULE3
  property p_trig_min;
    @(posedge clk) disable iff (!rst_n) $fell(triggered) |=> relay_triggered;
  endproperty
  a_trig_min: assert property (p_trig_min) else $error("trigger relay released early"); // see RULE20
  property p_rearm_notrig;
    @(posedge clk) disable iff (!rst_n) st_reg == RSA_ST_REARM |=> !manual_trigger;
  endproperty
  a_rearm_notrig: assert property (p_rearm_notrig) else $error("rearm made test record"); // see RULE18
  property p_disarm_log;
    @(posedge clk) disable iff (!rst_n) st_reg == RSA_ST_ARMED && long_hold |=> log_disarm && st_reg == RSA_ST_DISARMED;
  endproperty
  a_disarm_log: assert property (p_disarm_log) else $error("disarm not logged"); // see RULE19
  property p_relay_mirror;
    @(posedge clk) disable iff (!rst_n) relay_online == led_online && relay_attention == led_attention;
  endproperty
  a_relay_mirror: assert property (p_relay_mirror) else $error("relay differs from lamp"); // see RULE21
  property p_offline_disarmed;
    @(posedge clk) disable iff (!rst_n) st_reg == RSA_ST_DISARMED |=> !led_online;
  endproperty
  a_offline_disarmed: assert property (p_offline_disarmed) else $error("on-line lit while disarmed"); // see RULE16
endmodule
`default_nettype wire

// ==== testbench/rsa_operator.sv ====
// rsa_operator: front-panel operator working the test button
// assumes button high = pressed, sampled on a slow tick of TICK cycles
`timescale 1ns/1ps
`default_nettype none
module rsa_operator #(
  parameter int unsigned TICK = 10
) (
  input wire logic clk,
  output var logic btn_raw
);
  initial btn_raw = 1'b0;
  // real contacts bounce at make and break, so the debounce must cope
  task automatic press(input int unsigned ticks);
    for (int i = 0; i < 7; i++) begin
      @(negedge clk);
      btn_raw = ~btn_raw;
    end
    repeat (ticks * TICK) @(negedge clk);
    for (int i = 0; i < 5; i++) begin
      @(negedge clk);
      btn_raw = ~btn_raw;
    end
  endtask
endmodule
`default_nettype wire

// ==== testbench/tb.sv ====
// tb: self-checking bench for the recorder status annunciator
// assumes rsa_top and rsa_operator are compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rsa_pkg::*;
  localparam int unsigned TK = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_ok = 1'b1, selftest_done = 1'b0, selftest_fail = 1'b0, acquiring = 1'b1;
  logic record_ready = 1'b0, dir_read = 1'b0, flash_writing = 1'b0, flash_fault = 1'b0;
  logic log_read = 1'b0, gps_lock = 1'b1, remote_fault = 1'b0, triggered = 1'b0, printer_present = 1'b1;
  logic [N_CHAN-1:0] chan_req = 2'h0;
  logic [N_CHAN-1:0] chan_end = 2'h0;
  logic [N_SENS-1:0] sens_ok = 4'hF;
  logic [N_SENS*8-1:0] sens_temp = 32'h1919_1919;
  logic btn_raw, led_power, led_online, led_data, led_comms, led_attention, led_time_fault;
  logic led_storage_fault, led_comms_fault, led_temp_fault, led_spare, relay_power, relay_online;
  logic relay_triggered, relay_attention, run_tests, manual_trigger, armed, log_disarm, log_rearm;
  logic log_test_fault, print_log, print_status, print_record, osc_holdover, tone_out;
  logic [N_CHAN-1:0] chan_grant;
  logic [7:0] pv;
  logic tone_q = 1'b0;
  int failures = 0;
  int n_checks = 0;
  int pc [8];
  int b [8];
  int n_tone = 0;
  logic [31:0] tt [4] = '{32'h1919_1919, 32'h1919_3D19, 32'h1919_1919, 32'h1919_2D19};
  logic [3:0] ok [4] = '{4'hF, 4'hF, 4'hB, 4'hF};
  logic ex [4] = '{1'b0, 1'b1, 1'b1, 1'b1};

  always #5 clk = ~clk;

  rsa_top #(.GPS_LOSS(30), .HOLD(60), .TICK(TK)) rsa_top_i (
    .clk, .rst_n, .supply_ok, .selftest_done, .selftest_fail, .acquiring, .record_ready,
    .dir_read, .flash_writing, .flash_fault, .chan_req, .chan_end, .log_read, .gps_lock,
    .remote_fault, .sens_ok, .sens_temp, .triggered, .printer_present, .btn_raw, .led_power,
    .led_online, .led_data, .led_comms, .led_attention, .led_time_fault, .led_storage_fault,
    .led_comms_fault, .led_temp_fault, .led_spare, .relay_power, .relay_online, .relay_triggered,
    .relay_attention, .chan_grant, .run_tests, .manual_trigger, .armed, .log_disarm, .log_rearm,
    .log_test_fault, .print_log, .print_status, .print_record, .osc_holdover, .tone_out
  );
  rsa_operator #(.TICK(TK)) rsa_operator_i (.clk, .btn_raw);

  // pulse outputs are counted, so a missing pulse shows, and a doubled one except on print_status and print_log
  assign pv = {print_record, print_status, print_log, log_test_fault, log_rearm, log_disarm,
               manual_trigger, run_tests};
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (pv[i] === 1'b1) pc[i]++;
    end
    tone_q <= tone_out;
    if (rst_n === 1'b1 && tone_out !== tone_q) n_tone++;
  end

  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic [31:0] d(input int i);
    return 32'(pc[i] - b[i]);
  endfunction
  task automatic final_report();
    if (failures == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    cyc(4);
    check("power_in_reset", led_power, 0);
    cyc(4);
    rst_n = 1'b1;
    cyc(4);
    check("led_power", led_power, 1);
    check("relay_power", relay_power, 1);
    check("online_early", led_online, 0);
    check("led_spare", led_spare, 0);
    selftest_done = 1'b1;
    cyc(1);
    selftest_done = 1'b0;
    cyc(4);
    check("online", led_online, 1);
    check("relay_online", relay_online, 1);
    check("armed", armed, 1);
    flash_writing = 1'b1;
    record_ready = 1'b1;
    cyc(1);
    record_ready = 1'b0;
    flash_writing = 1'b0;
    cyc(3);
    check("data_on", led_data, 1);
    dir_read = 1'b1;
    cyc(1);
    dir_read = 1'b0;
    cyc(3);
    check("data_off", led_data, 0);
    flash_fault = 1'b1;
    remote_fault = 1'b1;
    cyc(3);
    check("storage_fault", led_storage_fault, 1);
    check("comms_fault", led_comms_fault, 1);
    flash_fault = 1'b0;
    remote_fault = 1'b0;
    cyc(3);
    check("comms_fault_off", led_comms_fault, 0);
    for (int i = 0; i < 4; i++) begin
      sens_temp = tt[i];
      sens_ok = ok[i];
      cyc(4);
      check("temp_fault", led_temp_fault, 32'(ex[i]));
    end
    sens_temp = 32'h1919_1919;
    sens_ok = 4'hF;
    chan_req = 2'h3;
    cyc(4);
    check("grant_first", chan_grant, 2'h1);
    check("comms_on", led_comms, 1);
    chan_req = 2'h2;
    chan_end = 2'h1;
    cyc(1);
    chan_end = 2'h0;
    cyc(4);
    check("grant_second", chan_grant, 2'h2);
    chan_req = 2'h0;
    chan_end = 2'h2;
    cyc(1);
    chan_end = 2'h0;
    cyc(4);
    check("comms_off", led_comms, 0);
    selftest_fail = 1'b1;
    cyc(1);
    selftest_fail = 1'b0;
    cyc(30);
    check("attention_held", led_attention, 1);
    check("relay_attention", relay_attention, 1);
    log_read = 1'b1;
    cyc(1);
    log_read = 1'b0;
    cyc(3);
    check("attention_clear", relay_attention, 0);
    b = pc;
    rsa_operator_i.press(35);
    cyc(40 * TK);
    check("run_tests", d(0), 1);
    check("no_early_trigger", d(1), 0);
    selftest_done = 1'b1;
    selftest_fail = 1'b1;
    cyc(1);
    selftest_done = 1'b0;
    selftest_fail = 1'b0;
    cyc(5);
    check("manual_trigger", d(1), 1);
    check("log_test_fault", d(4), 1);
    check("test_attention", led_attention, 1);
    check("print_status", 32'(d(6) != 0), 1);
    log_read = 1'b1;
    cyc(1);
    log_read = 1'b0;
    triggered = 1'b1;
    cyc(3);
    check("trig_relay", relay_triggered, 1);
    triggered = 1'b0;
    cyc(480 * TK);
    check("trig_min_on", relay_triggered, 1);
    cyc(50 * TK);
    check("trig_release", relay_triggered, 0);
    check("print_record", d(7), 1);
    gps_lock = 1'b0;
    cyc(20 * TK);
    check("time_fault_early", led_time_fault, 0);
    cyc(25 * TK);
    check("time_fault", led_time_fault, 1);
    check("holdover", osc_holdover, 1);
    check("online_holdover", led_online, 1);
    gps_lock = 1'b1;
    check("no_tone_yet", n_tone, 0);
    b = pc;
    rsa_operator_i.press(100);
    cyc(40 * TK);
    check("log_disarm", d(2), 1);
    check("hold_no_test", d(0), 0);
    check("online_out", led_online, 0);
    check("relay_online_out", relay_online, 0);
    check("print_log", 32'(d(5) != 0), 1);
    // first half period of the sweep is the longest, hence the wait
    cyc(25500);
    check("tone_runs", 32'(n_tone != 0), 1);
    b = pc;
    printer_present = 1'b0;
    rsa_operator_i.press(35);
    cyc(40 * TK);
    check("log_rearm", d(3), 1);
    check("no_printer", d(5), 0);
    check("rearm_no_trigger", d(1), 0);
    check("rearm_no_test", d(0), 0);
    check("rearm_online", led_online, 1);
    final_report();
  end

  initial begin
    cyc(80000);
    failures++;
    final_report();
  end
endmodule
`default_nettype wire
